// ### rtl/visa_front.sv
// Functional notes
// - decode selector into composite, s-video, component
// - two paths with gain, clamp, 8-bit converter
// - composite uses luma path only
// - s-video and component enable both paths
// - gain and clamp corrections fed back
// - gain regulates tip to porch difference
// - target select low: tip 2, porch 70
// - target select high: tip 16, porch 70
// - overflow backoff lowers gain at max code
// - freeze holds gain
// - frozen gain takes manual value
// - two-bit time constant selects loop speed
// - speedup doubles tracking rate before lock
// - expansion port feeds scaler through a fifo
// - digital input is 8-bit 656 stream
// - input path field picks analog or digital
// - digital input as timing master or slave
`timescale 1ns/1ps
`default_nettype none
module visa_front
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // command register b and tracking control b bits
  input wire logic [3:0] input_source_select,
  input wire logic gain_target_select,
  input wire logic overflow_gain_backoff_en,
  input wire logic gain_freeze,
  input wire logic [7:0] manual_gain_value,
  input wire logic [1:0] gain_loop_time_const,
  input wire logic acquisition_speedup,
  input wire logic [1:0] input_path_select,
  input wire logic timing_master,
  // converter samples and sampling windows
  input wire logic [7:0] luma_adc,
  input wire logic [7:0] chroma_adc,
  input wire logic sync_tip_strobe,
  input wire logic back_porch_strobe,
  // analog mux controls
  output logic [2:0] luma_mux_sel,
  output logic [2:0] chroma_mux_sel,
  output logic luma_path_en,
  output logic chroma_path_en,
  output logic select_reserved,
  // analog stage controls
  output logic [7:0] luma_gain,
  output logic [7:0] chroma_gain,
  output logic [7:0] luma_clamp,
  output logic [7:0] chroma_clamp,
  output logic gain_locked,
  // expansion video port, three signals per pin
  input wire logic [7:0] expansion_video_port_in,
  output logic [7:0] expansion_video_port_out,
  output logic [7:0] expansion_video_port_oe,
  input wire logic [7:0] decoded_video,
  // external sync lines for slave mode
  input wire logic ext_hsync,
  input wire logic ext_vsync,
  input wire logic use_ext_sync,
  // scaler feed
  output logic scaler_valid,
  input wire logic scaler_ready,
  output logic [7:0] scaler_data,
  output logic scaler_line_start,
  output logic digital_active,
  output logic ext_timing_follow
);
  logic [2:0] nxt_luma_mux;
  logic [2:0] nxt_chroma_mux;
  logic nxt_luma_en;
  logic nxt_chroma_en;
  logic nxt_reserved;
  localparam int ACC_W_L = visa_pkg::ACC_W;
  logic [ACC_W_L-1:0] gain_acc_ff;
  logic [ACC_W_L-1:0] cl_y_acc_ff;
  logic [ACC_W_L-1:0] cl_c_acc_ff;
  logic [7:0] tip_y_ff;
  logic [3:0] lock_cnt_ff;
  logic locked_ff;
  logic ovf_ff;
  logic [7:0] frozen_gain_ff;
  logic freeze_d_ff;
  logic signed [9:0] gain_err;
  logic signed [9:0] cl_y_err;
  logic signed [9:0] cl_c_err;
  logic [7:0] tip_target;
  logic [3:0] shift;
  logic digital_sel;
  visa_pkg::visa_sync_e sync_st_ff;
  logic line_start_ff;
  logic fifo_in_valid;

  // selector decode; unlisted codes switch both paths off
  always_comb
  begin
    nxt_luma_mux = '0;
    nxt_chroma_mux = '0;
    nxt_luma_en = 1'b0;
    nxt_chroma_en = 1'b0;
    nxt_reserved = 1'b0;
    case (input_source_select)
      4'h0, 4'h1, 4'h2:
      begin
        nxt_luma_mux = 3'(input_source_select[1:0]);
        nxt_luma_en = 1'b1;
      end
      4'h4, 4'h5, 4'h6:
      begin
        // chroma pin routed into luma converter for composite
        nxt_luma_mux = 3'h4 | 3'(input_source_select[1:0]);
        nxt_luma_en = 1'b1;
      end
      4'h8, 4'h9, 4'hA:
      begin
        nxt_luma_mux = 3'(input_source_select[1:0]);
        nxt_chroma_mux = 3'(input_source_select[1:0]);
        nxt_luma_en = 1'b1;
        nxt_chroma_en = 1'b1;
      end
      4'hF:
      begin
        // y on third luma pin, cb/cr both on second chroma pin (select 1)
        nxt_luma_mux = 3'h2;
        nxt_chroma_mux = 3'h1;
        nxt_luma_en = 1'b1;
        nxt_chroma_en = 1'b1;
      end
      default:
        nxt_reserved = 1'b1;
    endcase
  end

  // registered mux controls
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      luma_mux_sel <= 3'h0;
      chroma_mux_sel <= 3'h0;
      luma_path_en <= 1'b0;
      chroma_path_en <= 1'b0;
      select_reserved <= 1'b0;
    end
    else
    begin
      luma_mux_sel <= nxt_luma_mux;
      chroma_mux_sel <= nxt_chroma_mux;
      luma_path_en <= nxt_luma_en && !digital_sel;
      chroma_path_en <= nxt_chroma_en && !digital_sel;
      select_reserved <= nxt_reserved;
    end
  end

  // tip target picked by target select, porch fixed
  assign tip_target = gain_target_select ? visa_pkg::CODE_TIP_HI
                                         : visa_pkg::CODE_TIP_LO;
  // error = wanted swing minus measured swing
  assign gain_err = $signed({2'b00, visa_pkg::CODE_PORCH})
                  - $signed({2'b00, tip_target})
                  - ($signed({2'b00, luma_adc}) - $signed({2'b00, tip_y_ff}));
  // clamp error pulls porch onto its code
  assign cl_y_err = $signed({2'b00, visa_pkg::CODE_PORCH})
                  - $signed({2'b00, luma_adc});
  assign cl_c_err = $signed({2'b00, visa_pkg::CODE_PORCH})
                  - $signed({2'b00, chroma_adc});
  // slower constant means bigger shift; speedup lowers it by one before lock
  assign shift = 4'(visa_pkg::SHIFT_BASE) + {2'b00, gain_loop_time_const}
               - {3'b000, acquisition_speedup && !locked_ff};

  // sync tip sample capture
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      tip_y_ff <= visa_pkg::CODE_TIP_LO;
    else if (sync_tip_strobe)
      tip_y_ff <= luma_adc;
  end

  // overflow seen anywhere in the line; a hit on the clear cycle wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ovf_ff <= 1'b0;
    else if (luma_adc == visa_pkg::CODE_MAX
             || chroma_adc == visa_pkg::CODE_MAX)
      ovf_ff <= 1'b1;
    else if (back_porch_strobe)
      ovf_ff <= 1'b0;
  end

  // gain integrator, updated once per line at back porch
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gain_acc_ff <= {visa_pkg::GAIN_RST, 8'h00};
    else if (gain_freeze)
      gain_acc_ff <= gain_acc_ff;
    else if (back_porch_strobe && overflow_gain_backoff_en && ovf_ff)
    begin
      // backoff wins over normal tracking
      if (gain_acc_ff[ACC_W_L-1:8] != 8'h00)
        gain_acc_ff <= gain_acc_ff - 16'h0100;
    end
    else if (back_porch_strobe)
      gain_acc_ff <= sat_add(gain_acc_ff,
                             16'($signed(gain_err) <<< 6) >>> shift);
  end

  // saturating add of signed step
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic signed [15:0] d);
    logic signed [17:0] s;
    s = $signed({2'b00, a}) + 18'(d);
    if (s < 0)
      sat_add = 16'h0000;
    else if (s > 18'sh0FFFF)
      sat_add = 16'hFFFF;
    else
      sat_add = s[15:0];
  endfunction : sat_add

  // clamp integrators track porch code
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cl_y_acc_ff <= {visa_pkg::CLAMP_RST, 8'h00};
      cl_c_acc_ff <= {visa_pkg::CLAMP_RST, 8'h00};
    end
    else if (back_porch_strobe)
    begin
      cl_y_acc_ff <= sat_add(cl_y_acc_ff,
                             16'($signed(cl_y_err) <<< 6) >>> shift);
      if (chroma_path_en)
        cl_c_acc_ff <= sat_add(cl_c_acc_ff,
                               16'($signed(cl_c_err) <<< 6) >>> shift);
    end
  end

  // gain held at freeze; manual value then drives the stage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      freeze_d_ff <= 1'b0;
      frozen_gain_ff <= visa_pkg::GAIN_RST;
    end
    else
    begin
      freeze_d_ff <= gain_freeze;
      if (gain_freeze && !freeze_d_ff)
        frozen_gain_ff <= gain_acc_ff[15:8];
      else if (gain_freeze)
        frozen_gain_ff <= manual_gain_value;
    end
  end

  // lock after several quiet lines
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt_ff <= 4'h0;
      locked_ff <= 1'b0;
    end
    else if (back_porch_strobe)
    begin
      if (gain_err > $signed({1'b0, visa_pkg::LOCK_WIN})
          || gain_err < -$signed({1'b0, visa_pkg::LOCK_WIN}))
      begin
        lock_cnt_ff <= 4'h0;
        locked_ff <= 1'b0;
      end
      else if (lock_cnt_ff == visa_pkg::LOCK_LINES)
        locked_ff <= 1'b1;
      else
        lock_cnt_ff <= lock_cnt_ff + 4'h1;
    end
  end

  // stage outputs; both paths share one gain word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      luma_gain <= visa_pkg::GAIN_RST;
      chroma_gain <= visa_pkg::GAIN_RST;
      luma_clamp <= visa_pkg::CLAMP_RST;
      chroma_clamp <= visa_pkg::CLAMP_RST;
      gain_locked <= 1'b0;
    end
    else
    begin
      luma_gain <= gain_freeze ? frozen_gain_ff : gain_acc_ff[15:8];
      chroma_gain <= gain_freeze ? frozen_gain_ff : gain_acc_ff[15:8];
      luma_clamp <= cl_y_acc_ff[15:8];
      chroma_clamp <= cl_c_acc_ff[15:8];
      gain_locked <= locked_ff;
    end
  end

  // digital input path selection
  assign digital_sel = (input_path_select != visa_pkg::PATH_ANALOG);
  assign digital_active = digital_sel;
  assign ext_timing_follow = digital_sel && !timing_master;

  // port drives decoded video only in analog mode
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      expansion_video_port_out <= 8'h00;
      expansion_video_port_oe <= 8'h00;
    end
    else
    begin
      expansion_video_port_out <= decoded_video;
      expansion_video_port_oe <= digital_sel ? 8'h00 : 8'hFF;
    end
  end

  // 656 preamble hunt: FF 00 00 then code word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_st_ff <= visa_pkg::SYNC_IDLE;
      line_start_ff <= 1'b0;
    end
    else
    begin
      line_start_ff <= 1'b0;
      case (sync_st_ff)
        visa_pkg::SYNC_IDLE:
          if (expansion_video_port_in == visa_pkg::SAV_FF)
            sync_st_ff <= visa_pkg::SYNC_FF;
        // a run of FF keeps hunting so the preamble is never missed
        visa_pkg::SYNC_FF:
          if (expansion_video_port_in == visa_pkg::SAV_00)
            sync_st_ff <= visa_pkg::SYNC_Z1;
          else if (expansion_video_port_in != visa_pkg::SAV_FF)
            sync_st_ff <= visa_pkg::SYNC_IDLE;
        visa_pkg::SYNC_Z1:
          sync_st_ff <= (expansion_video_port_in == visa_pkg::SAV_00)
                      ? visa_pkg::SYNC_Z2 : visa_pkg::SYNC_IDLE;
        visa_pkg::SYNC_Z2:
        begin
          // code word: bit4 low marks start of active video
          sync_st_ff <= visa_pkg::SYNC_IDLE;
          line_start_ff <= !expansion_video_port_in[4] && !use_ext_sync;
        end
        default:
          sync_st_ff <= visa_pkg::SYNC_IDLE;
      endcase
    end
  end

  // slave timing from sync lines or embedded codes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      scaler_line_start <= 1'b0;
    else if (ext_timing_follow)
      scaler_line_start <= use_ext_sync ? (ext_hsync && !ext_vsync)
                                        : line_start_ff;
    else
      scaler_line_start <= 1'b0;
  end

  // fifo absorbs scaler stalls; preamble bytes are not data
  assign fifo_in_valid = digital_sel
                      && expansion_video_port_in != visa_pkg::SAV_FF
                      && sync_st_ff == visa_pkg::SYNC_IDLE;

  visa_fifo #(
    .WIDTH(visa_pkg::FIFO_W),
    .DEPTH(visa_pkg::FIFO_D)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(),
    .in_data(expansion_video_port_in),
    .out_valid(scaler_valid),
    .out_ready(scaler_ready),
    .out_data(scaler_data)
  );
endmodule : visa_front
`default_nettype wire

// ### pkg/visa_pkg.sv
package visa_pkg;
  // input selector codes
  localparam logic [3:0] SEL_CVBS_Y0 = 4'h0;
  localparam logic [3:0] SEL_CVBS_Y2 = 4'h2;
  localparam logic [3:0] SEL_CVBS_C0 = 4'h4;
  localparam logic [3:0] SEL_CVBS_C2 = 4'h6;
  localparam logic [3:0] SEL_SVID_0 = 4'h8;
  localparam logic [3:0] SEL_SVID_2 = 4'hA;
  localparam logic [3:0] SEL_COMP = 4'hF;
  // converter codes
  localparam logic [7:0] CODE_TIP_LO = 8'h02;
  localparam logic [7:0] CODE_TIP_HI = 8'h10;
  localparam logic [7:0] CODE_PORCH = 8'h46;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  // gain/clamp reset values
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [7:0] CLAMP_RST = 8'h80;
  // input path encodings
  localparam logic [1:0] PATH_ANALOG = 2'h0;
  // lock: consecutive lines with error inside window
  localparam logic [3:0] LOCK_LINES = 4'h8;
  localparam logic [8:0] LOCK_WIN = 9'h004;
  // loop integrator width and base shift
  localparam int ACC_W = 16;
  localparam int SHIFT_BASE = 2;
  // fifo geometry
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  // itu 656 sync bytes
  localparam logic [7:0] SAV_FF = 8'hFF;
  localparam logic [7:0] SAV_00 = 8'h00;
  typedef enum logic [1:0]
  {
    SYNC_IDLE = 2'b00,
    SYNC_FF = 2'b01,
    SYNC_Z1 = 2'b10,
    SYNC_Z2 = 2'b11
  } visa_sync_e;
endpackage : visa_pkg

// ### rtl/visa_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module visa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // honest full and empty from occupancy
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];

  // storage has no reset, only pointers and count do
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  // pointers wrap at depth
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : visa_fifo
`default_nettype wire

// ### testbench/visa_checker.sv
`timescale 1ns/1ps
`default_nettype none
module visa_checker
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // controls
  input wire logic [3:0] input_source_select,
  input wire logic overflow_gain_backoff_en,
  input wire logic gain_freeze,
  input wire logic [7:0] manual_gain_value,
  input wire logic [1:0] input_path_select,
  input wire logic timing_master,
  input wire logic [7:0] luma_adc,
  input wire logic scaler_ready,
  // watched outputs
  input wire logic luma_path_en,
  input wire logic chroma_path_en,
  input wire logic select_reserved,
  input wire logic [7:0] luma_gain,
  input wire logic scaler_valid,
  input wire logic [7:0] scaler_data,
  input wire logic digital_active,
  input wire logic ext_timing_follow
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // settings held three cycles (freeze and overflow four) before outputs are judged
  sequence s_sel;
    ($stable(input_source_select) && $stable(input_path_select)) [*3];
  endsequence
  sequence s_path;
    ($stable(input_path_select) && $stable(timing_master)) [*3];
  endsequence
  sequence s_frz;
    (gain_freeze && $stable(manual_gain_value)) [*4];
  endsequence
  sequence s_ovf;
    (overflow_gain_backoff_en && !gain_freeze
      && luma_adc == visa_pkg::CODE_MAX) [*4];
  endsequence
  property p_comp;
    s_sel ##0 (!input_source_select[3] && input_source_select[1:0] != 2'h3
      && input_path_select == visa_pkg::PATH_ANALOG)
      |-> luma_path_en && !chroma_path_en;
  endproperty
  a_comp: assert property (p_comp)
    else $error("composite path enables wrong");
  property p_dual;
    s_sel ##0 (input_source_select inside {4'h8, 4'h9, 4'hA, 4'hF}
      && input_path_select == visa_pkg::PATH_ANALOG)
      |-> luma_path_en && chroma_path_en;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual path enables wrong");
  property p_rsv;
    s_sel |-> select_reserved ==
      (input_source_select inside {4'h3, 4'h7, [4'hB:4'hE]});
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved flag wrong");
  property p_rst_gain;
    $fell(rst) |-> luma_gain == visa_pkg::GAIN_RST;
  endproperty
  a_rst_gain: assert property (p_rst_gain)
    else $error("gain not at reset value");
  property p_frz;
    s_frz |-> luma_gain == manual_gain_value;
  endproperty
  a_frz: assert property (p_frz)
    else $error("frozen gain not manual value");
  property p_ovf;
    s_ovf |-> luma_gain <= $past(luma_gain, 3);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("gain rose at max code");
  property p_path;
    s_path |-> digital_active ==
      (input_path_select != visa_pkg::PATH_ANALOG);
  endproperty
  a_path: assert property (p_path)
    else $error("input path choice wrong");
  property p_follow;
    s_path ##0 digital_active |-> ext_timing_follow == !timing_master;
  endproperty
  a_follow: assert property (p_follow)
    else $error("timing master or slave wrong");
  property p_hold;
    scaler_valid && !scaler_ready |=> scaler_valid && $stable(scaler_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("scaler word dropped while stalled");
endmodule : visa_checker
bind visa_front visa_checker u_chk
(
  .clock, .rst, .input_source_select, .overflow_gain_backoff_en,
  .gain_freeze, .manual_gain_value, .input_path_select, .timing_master,
  .luma_adc, .scaler_ready, .luma_path_en, .chroma_path_en,
  .select_reserved, .luma_gain, .scaler_valid, .scaler_data,
  .digital_active, .ext_timing_follow
);
`default_nettype wire

// ### testbench/visa_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module visa_source_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench requests
  input wire logic line_go,
  input wire logic sav_go,
  input wire logic hot,
  input wire logic [7:0] amp,
  input wire logic [7:0] luma_gain,
  // converter and port side
  output logic [7:0] luma_adc,
  output logic [7:0] port_drive,
  // line timing strobes
  output logic tip_stb,
  output logic porch_stb
);
  logic [4:0] pos_ff;
  logic dig_ff;
  logic [15:0] swing;
  // sync depth scales with gain so the loop really closes
  assign swing = ({8'h00, amp} * {8'h00, luma_gain}) >> 7;
  // one 16-cycle line or 656 burst per request
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pos_ff <= 5'h00;
      dig_ff <= 1'b0;
    end
    else
    begin
      if (pos_ff != 5'h00)
        pos_ff <= (pos_ff == 5'h10) ? 5'h00 : pos_ff + 5'h01;
      else if (line_go || sav_go)
      begin
        pos_ff <= 5'h01;
        dig_ff <= sav_go;
      end
    end
  end
  // tip sampled mid-tip, porch sampled once the tip is over
  assign tip_stb = !dig_ff && pos_ff == 5'h03;
  assign porch_stb = !dig_ff && pos_ff == 5'h06;
  // tip at 3, porch level elsewhere, active video from 9
  always_comb
  begin
    luma_adc = visa_pkg::CODE_PORCH;
    if (!dig_ff && pos_ff == 5'h03)
      luma_adc = (swing > 16'h0046) ? 8'h00 : 8'h46 - swing[7:0];
    else if (!dig_ff && pos_ff > 5'h08)
      luma_adc = hot ? 8'hFF : 8'h80;
  end
  // sav then eight payload bytes; idle parks at FF so nothing is queued
  always_comb
  begin
    port_drive = visa_pkg::SAV_FF;
    if (dig_ff && pos_ff == 5'h01)
      port_drive = visa_pkg::SAV_FF;
    else if (dig_ff && (pos_ff == 5'h02 || pos_ff == 5'h03))
      port_drive = visa_pkg::SAV_00;
    else if (dig_ff && pos_ff == 5'h04)
      port_drive = 8'h80;
    else if (dig_ff && pos_ff >= 5'h05 && pos_ff <= 5'h0C)
      port_drive = 8'h0B + {3'h0, pos_ff};
  end
endmodule : visa_source_model
`default_nettype wire

// ### testbench/video_input_select_agc_bench.sv
`timescale 1ns/1ps
`default_nettype none
module video_input_select_agc_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sel = 4'h0;
  logic tgt = 1'b0, ovf = 1'b0, frz = 1'b0, spd = 1'b0, mst = 1'b0;
  logic rdy = 1'b0, line_go = 1'b0, sav_go = 1'b0, hot = 1'b0;
  logic [1:0] tc = 2'h0, path = 2'h0;
  logic [7:0] man = 8'h00, ladc, p_in, p_out, p_oe, p_drv, gain, sdat, clmp;
  logic tstb, pstb, ls, lock, svld, dact, fol, len, cen, rsv;
  int ls_cnt = 0;
  int miscompares = 0;
  int cmp_count = 0;
  int i, n, g0;
  // half period of a 40 MHz clock
  always #12.5 clock = ~clock;
  // pin level: our port wins only where it drives
  assign p_in = (p_oe & p_out) | (~p_oe & p_drv);
  // count line start pulses handed to the scaler
  always @(posedge clock)
    if (ls === 1'b1)
      ls_cnt <= ls_cnt + 1;
  visa_front uut
  (
    .clock(clock), .rst(rst), .input_source_select(sel),
    .gain_target_select(tgt), .overflow_gain_backoff_en(ovf),
    .gain_freeze(frz), .manual_gain_value(man),
    .gain_loop_time_const(tc), .acquisition_speedup(spd),
    .input_path_select(path), .timing_master(mst), .luma_adc(ladc),
    .chroma_adc(8'h80), .sync_tip_strobe(tstb),
    .back_porch_strobe(pstb), .luma_mux_sel(), .chroma_mux_sel(),
    .luma_path_en(len), .chroma_path_en(cen), .select_reserved(rsv),
    .luma_gain(gain), .chroma_gain(), .luma_clamp(clmp),
    .chroma_clamp(), .gain_locked(lock), .expansion_video_port_in(p_in),
    .expansion_video_port_out(p_out), .expansion_video_port_oe(p_oe),
    .decoded_video(p_drv), .ext_hsync(1'b0), .ext_vsync(1'b0),
    .use_ext_sync(1'b0), .scaler_valid(svld), .scaler_ready(rdy),
    .scaler_data(sdat), .scaler_line_start(ls), .digital_active(dact),
    .ext_timing_follow(fol)
  );
  visa_source_model src
  (
    .clock(clock), .rst(rst), .line_go(line_go), .sav_go(sav_go),
    .hot(hot), .amp(8'd60), .luma_gain(gain), .luma_adc(ladc),
    .port_drive(p_drv), .tip_stb(tstb), .porch_stb(pstb)
  );
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic run_lines(input int k);
    repeat (k)
    begin
      @(posedge clock);
      line_go <= 1'b1;
      @(posedge clock);
      line_go <= 1'b0;
      repeat (17) @(posedge clock);
    end
  endtask : run_lines
  // settle, then measured tip-porch span must sit in the lock window
  task automatic lock_test(input int d);
    int k;
    int sw;
    k = 0;
    run_lines(20);
    while (lock !== 1'b1 && k < 400)
    begin
      run_lines(1);
      k++;
    end
    sw = (60 * int'(gain)) >> 7;
    chk1("locked", 1'b1, lock);
    chk1("tip span", 1'b1, sw >= d - 4 && sw <= d + 4);
  endtask : lock_test
  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // watchdog, well beyond the longest lock searches
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk8("gain reset", visa_pkg::GAIN_RST, gain);
    chk8("clamp reset", visa_pkg::CLAMP_RST, clmp);
    for (i = 0; i < 16; i++)
    begin
      sel <= i[3:0];
      repeat (4) @(posedge clock);
      chk1("chroma en", i inside {8, 9, 10, 15}, cen);
      chk1("luma en", !(i inside {3, 7, [11:14]}), len);
      chk1("reserved", i inside {3, 7, [11:14]}, rsv);
    end
    sel <= 4'h0;
    spd <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      tc <= i[1:0];
      tgt <= i[0];
      lock_test(i[0] ? 54 : 68);
    end
    ovf <= 1'b1;
    hot <= 1'b1;
    g0 = int'(gain);
    run_lines(20);
    chk1("backoff", 1'b1, int'(gain) < g0);
    g0 = int'(gain);
    hot <= 1'b0;
    man <= 8'h5A;
    frz <= 1'b1;
    repeat (4) @(posedge clock);
    chk8("manual gain", 8'h5A, gain);
    run_lines(3);
    chk8("frozen gain", 8'h5A, gain);
    frz <= 1'b0;
    repeat (2) @(posedge clock);
    chk8("held gain", 8'(g0), gain);
    path <= 2'h1;
    mst <= 1'b1;
    repeat (4) @(posedge clock);
    chk1("digital", 1'b1, dact);
    chk1("master", 1'b0, fol);
    chk8("port in", 8'h00, p_oe);
    mst <= 1'b0;
    repeat (4) @(posedge clock);
    chk1("slave", 1'b1, fol);
    sav_go <= 1'b1;
    @(posedge clock);
    sav_go <= 1'b0;
    repeat (24) @(posedge clock);
    rdy <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      n = 0;
      @(posedge clock);
      while (svld !== 1'b1 && n < 50)
      begin
        n++;
        @(posedge clock);
      end
      chk8("scaler byte", 8'h10 + i[7:0], sdat);
    end
    #1 chk1("drained", 1'b0, svld);
    chk1("line start", 1'b1, ls_cnt == 1);
    end_of_test();
  end
endmodule : video_input_select_agc_bench
`default_nettype wire
